// ===== hw/iem_interrupt_enable_mask.v
// Interrupt enable register and per-source request gating
`timescale 1ns/100ps
`include "iem_regs.vh"
module iem_interrupt_enable_mask (
    input  wire       mclk,                      // System clock, 25 MHz
    input  wire       reset,                     // Async reset, active high
    input  wire [7:0] sfr_addr,                  // Special-function register address
    input  wire       sfr_wr,                    // Write strobe, one cycle
    input  wire       sfr_rd,                    // Read strobe, one cycle
    input  wire [7:0] sfr_wdata,                 // Write data
    output reg  [7:0] sfr_rdata,                 // Read data, registered
    input  wire       ext_line0_pending,         // External line 0 pending flag
    input  wire       timer0_overflow_flag,      // Timer 0 overflow flag
    input  wire       ext_line1_input,           // External line 1 pending request
    input  wire       timer1_overflow_flag,      // Timer 1 overflow flag
    input  wire       uart_pending,              // UART receive or transmit flag
    input  wire       timer2_low_overflow_flag,  // Timer 2 low-byte overflow
    input  wire       timer2_high_overflow_flag, // Timer 2 high-byte overflow
    input  wire       spi_pending,               // Any SPI port pending flag
    output reg  [6:0] irq_request,               // Gated requests, bit n = source n
    output reg  [7:0] irq_enable_reg             // Register contents to core
);

    // Working notes for whoever wires this block to the core:
    // - One 8-bit enable register; bit 7 gates all, bits 6..0 mask a source each.
    // - Every field is read/write and the register clears to zero on reset.
    // - Out of reset nothing can request until software sets the gate.
    // - Requests are levels, not pulses; a flag left set keeps requesting.
    // - So a flag still set after the handler returns requests again at once.
    // - Flags are cleared at the peripheral, never here.
    // - Timer 2 has two overflow flags behind one mask; either one requests.
    // - The SPI port folds all of its causes into one pending input.
    // - Each request leaves a flip-flop, so the core sees it one clock late.
    // - That clock of latency buys glitch-free request lines to the core.
    // - A write takes effect on the register at its own edge.
    // - Requests follow the new masks one edge after that.
    // - Reads have no side effects; read and write together return old data.
    // - Read data stands for one cycle only, then drops back to zero.
    // - Unmapped addresses are ignored and read back as zero.
    // - No error is flagged for an unmapped access; the core never waits.
    // - Priority and vectoring live in the core, not in this block.

    // Register layout, most significant bit first:
    //   7  global gate
    //   6  SPI port mask
    //   5  Timer 2 mask
    //   4  UART mask
    //   3  Timer 1 mask
    //   2  external line 1 mask
    //   1  Timer 0 mask
    //   0  external line 0 mask
    // Request bit n follows register bit n for n below 7.

    // Field views of the enable register
    wire       global_irq_gate;     // Bit 7, master gate
    wire       spi_irq_mask;        // Bit 6, SPI port
    wire       timer2_irq_mask;     // Bit 5, Timer 2
    wire       uart_irq_mask;       // Bit 4, UART
    wire       timer1_irq_mask;     // Bit 3, Timer 1
    wire       ext_line1_irq_mask;  // Bit 2, external line 1
    wire       timer0_irq_mask;     // Bit 1, Timer 0
    wire       ext_line0_irq_mask;  // Bit 0, external line 0

    // Timer 2 causes merged
    wire       timer2_pending;      // Either Timer 2 overflow

    // Per-source gated requests
    wire       ext_line0_gated;     // Source 0
    wire       timer0_gated;        // Source 1
    wire       ext_line1_gated;     // Source 2
    wire       timer1_gated;        // Source 3
    wire       uart_gated;          // Source 4
    wire       timer2_gated;        // Source 5
    wire       spi_gated;           // Source 6

    // Next-state values
    reg  [7:0] nxt_enable;          // Enable register next value
    reg  [6:0] nxt_request;         // Request lines next value
    reg  [7:0] nxt_rdata;           // Read data next value

    // Field views of the enable register
    assign global_irq_gate    = irq_enable_reg[`IEM_BIT_GATE];
    assign spi_irq_mask       = irq_enable_reg[`IEM_BIT_SPI];
    assign timer2_irq_mask    = irq_enable_reg[`IEM_BIT_TIMER2];
    assign uart_irq_mask      = irq_enable_reg[`IEM_BIT_UART];
    assign timer1_irq_mask    = irq_enable_reg[`IEM_BIT_TIMER1];
    assign ext_line1_irq_mask = irq_enable_reg[`IEM_BIT_EXT1];
    assign timer0_irq_mask    = irq_enable_reg[`IEM_BIT_TIMER0];
    assign ext_line0_irq_mask = irq_enable_reg[`IEM_BIT_EXT0];

    // Timer 2 has two overflow causes sharing one mask
    assign timer2_pending = timer2_low_overflow_flag | timer2_high_overflow_flag;

    // Flag, mask and gate all needed; gate overrides every mask
    assign ext_line0_gated = ext_line0_pending & ext_line0_irq_mask & global_irq_gate;
    assign timer0_gated    = timer0_overflow_flag & timer0_irq_mask & global_irq_gate;
    assign ext_line1_gated = ext_line1_input & ext_line1_irq_mask & global_irq_gate;
    assign timer1_gated    = timer1_overflow_flag & timer1_irq_mask & global_irq_gate;
    assign uart_gated      = uart_pending & uart_irq_mask & global_irq_gate;
    assign timer2_gated    = timer2_pending & timer2_irq_mask & global_irq_gate;
    assign spi_gated       = spi_pending & spi_irq_mask & global_irq_gate;

    // Next register value; written field by field, all fields read/write
    always @*
    begin
        nxt_enable = irq_enable_reg;
        if (sfr_wr)
        begin
            case (sfr_addr)
                `IEM_ADDR_ENABLE:
                begin
                    nxt_enable[`IEM_BIT_GATE]   = sfr_wdata[`IEM_BIT_GATE];
                    nxt_enable[`IEM_BIT_SPI]    = sfr_wdata[`IEM_BIT_SPI];
                    nxt_enable[`IEM_BIT_TIMER2] = sfr_wdata[`IEM_BIT_TIMER2];
                    nxt_enable[`IEM_BIT_UART]   = sfr_wdata[`IEM_BIT_UART];
                    nxt_enable[`IEM_BIT_TIMER1] = sfr_wdata[`IEM_BIT_TIMER1];
                    nxt_enable[`IEM_BIT_EXT1]   = sfr_wdata[`IEM_BIT_EXT1];
                    nxt_enable[`IEM_BIT_TIMER0] = sfr_wdata[`IEM_BIT_TIMER0];
                    nxt_enable[`IEM_BIT_EXT0]   = sfr_wdata[`IEM_BIT_EXT0];
                end
                default:
                begin
                    nxt_enable = irq_enable_reg; // Unmapped writes ignored
                end
            endcase
        end
    end

    // Requests in core order; levels, so a flag left set re-requests at once
    always @*
    begin
        nxt_request                  = 7'h00;
        nxt_request[`IEM_BIT_EXT0]   = ext_line0_gated;
        nxt_request[`IEM_BIT_TIMER0] = timer0_gated;
        nxt_request[`IEM_BIT_EXT1]   = ext_line1_gated;
        nxt_request[`IEM_BIT_TIMER1] = timer1_gated;
        nxt_request[`IEM_BIT_UART]   = uart_gated;
        nxt_request[`IEM_BIT_TIMER2] = timer2_gated;
        nxt_request[`IEM_BIT_SPI]    = spi_gated;
    end

    // Read data; old value on a same-cycle write, zero when unmapped
    always @*
    begin
        nxt_rdata = 8'h00;
        if (sfr_rd)
        begin
            case (sfr_addr)
                `IEM_ADDR_ENABLE:
                begin
                    nxt_rdata = irq_enable_reg;
                end
                default:
                begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    // Enable register
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            irq_enable_reg <= `IEM_RESET_ENABLE;
        end
        else
        begin
            irq_enable_reg <= nxt_enable;
        end
    end

    // Request lines; registered so the core never sees a glitch
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            irq_request <= 7'h00;
        end
        else
        begin
            irq_request <= nxt_request;
        end
    end

    // Read data; reads have no side effects
    always @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            sfr_rdata <= 8'h00;
        end
        else
        begin
            sfr_rdata <= nxt_rdata;
        end
    end

endmodule // iem_interrupt_enable_mask

// ===== hw/iem_regs.vh
// Register map and field constants for the interrupt enable mask block
// Overview of operation
// - Bit 7 of the enable register is the global gate for all interrupts.
// - Global gate overrides every individual mask bit.
// - Gate at 0 blocks every source from the CPU.
// - Gate at 1 passes each source per its own mask bit.
// - Bit 6 masks all SPI port requests.
// - Bit 5 masks Timer 2; request from low or high overflow flag.
// - Bit 4 masks the UART interrupt.
// - Bit 3 masks Timer 1; request from its overflow flag.
// - Bit 2 masks external line 1 requests.
// - Bit 1 masks the Timer 0 interrupt.
// - Bit 0 masks external line 0 requests.
// - A flag still set and enabled after return raises a new request at once.
`ifndef IEM_REGS_VH
`define IEM_REGS_VH
`define IEM_ADDR_ENABLE  8'ha8
`define IEM_RESET_ENABLE 8'h00
`define IEM_BIT_GATE     7
`define IEM_BIT_SPI      6
`define IEM_BIT_TIMER2   5
`define IEM_BIT_UART     4
`define IEM_BIT_TIMER1   3
`define IEM_BIT_EXT1     2
`define IEM_BIT_TIMER0   1
`define IEM_BIT_EXT0     0
`endif

// ===== sim/iem_props.sv
// Port checker for the interrupt enable mask block
`timescale 1ns/100ps
module iem_props(input wire mclk,reset,sfr_wr,sfr_rd,spi_pending,timer1_overflow_flag,
 input wire [7:0] sfr_addr,sfr_wdata,sfr_rdata,irq_enable_reg,input wire [6:0] irq_request);
wire [7:0] e=irq_enable_reg; wire [6:0] q=irq_request; wire s=spi_pending;
default clocking @(posedge mclk); endclocking default disable iff (reset);
property p_off; !e[7]|=>q==0; endproperty
a_off: assert property(p_off) else $error("off");
property p_pre; !e[7]&&e[6]&&s|=>!q[6]; endproperty
a_pre: assert property(p_pre) else $error("pre");
property p_on; e==8'h80|=>q==0; endproperty
a_on: assert property(p_on) else $error("on");
property p_spi; 1|=>q[6]==$past(s&e[6]&e[7]); endproperty
a_spi: assert property(p_spi) else $error("spi");
property p_t1; 1|=>q[3]==$past(timer1_overflow_flag&e[3]&e[7]); endproperty
a_t1: assert property(p_t1) else $error("t1");
property p_lvl; e[7]&&e[6]&&s|=>q[6]; endproperty
a_lvl: assert property(p_lvl) else $error("lvl");
property p_wr; sfr_wr&&sfr_addr==8'ha8|=>e==$past(sfr_wdata); endproperty
a_wr: assert property(p_wr) else $error("wr");
property p_rd; sfr_rd&&sfr_addr==8'ha8|=>sfr_rdata==$past(e); endproperty
a_rd: assert property(p_rd) else $error("rd");
endmodule // iem_props
bind iem_interrupt_enable_mask iem_props i_props(.*);

// ===== sim/iem_src_model.sv
// Pending-flag source model
`timescale 1ns/100ps
module iem_src_model(input wire mclk,input wire [7:0] pat,output reg [7:0] flags=8'h00);
// Flags move just after an edge, like real peripheral flags
always @(posedge mclk) flags<=pat;
endmodule // iem_src_model

// ===== sim/tb_top.sv
// Random and corner-case bench for the interrupt enable mask
`timescale 1ns/100ps
module tb_top;
reg mclk=0,reset=1,sfr_wr=0,sfr_rd=0; reg [7:0] sfr_addr=0,sfr_wdata=0,p=0,r_ff=0,d_ff=0;
reg [6:0] q_ff=0; wire [7:0] f,sfr_rdata,irq_enable_reg; wire [6:0] irq_request; integer mismatches=0,n_checks=0,i;
always #20 mclk=~mclk;
iem_src_model i_src(.mclk(mclk),.pat(p),.flags(f));
iem_interrupt_enable_mask i_dut(.*,.ext_line0_pending(f[0]),.timer0_overflow_flag(f[1]),
 .ext_line1_input(f[2]),.timer1_overflow_flag(f[3]),.uart_pending(f[4]),.spi_pending(f[6]),
 .timer2_low_overflow_flag(f[5]),.timer2_high_overflow_flag(f[7]));
task chk(input [23:0] n,input [7:0] s,x); begin n_checks=n_checks+1; if(s!==x) begin
 mismatches=mismatches+1; $display("wrong value %0s exp %h seen %h",n,x,s); end end endtask
task wrap_up; begin $display("checks %0d mismatches %0d",n_checks,mismatches);
 if(mismatches==0&&n_checks>0) $display("TB: PASS"); else $display("TB: FAIL"); $finish; end endtask
task drv(input w,r,input [7:0] a,d,v); begin @(posedge mclk); sfr_wr<=w; sfr_rd<=r;
 sfr_addr<=a; sfr_wdata<=d; p<=v; end endtask
// Reference copy, sampled on the same edge as the block
always @(posedge mclk) if(!reset) begin q_ff<={f[6],f[5]|f[7],f[4:0]}&r_ff[6:0]&{7{r_ff[7]}};
 d_ff<=(sfr_rd&&sfr_addr==8'ha8)?r_ff:8'h00; if(sfr_wr&&sfr_addr==8'ha8) r_ff<=sfr_wdata; end
// Compare mid-cycle so every update has landed
always @(negedge mclk) begin chk("req",{1'b0,irq_request},{1'b0,q_ff});
 chk("reg",irq_enable_reg,r_ff);
 chk("rd",sfr_rdata,d_ff); end
initial begin #100000 mismatches=mismatches+1; wrap_up; end
// Gate off with all masks, read during write, all on, unmapped access, then random
initial begin i=$urandom(32'h79a6); repeat(5) @(posedge mclk); reset<=0;
 drv(1,1,8'ha8,8'h7f,8'hff); drv(0,1,8'ha8,0,8'hff); drv(1,0,8'ha8,8'hff,8'hff); drv(1,1,8'h10,0,0);
 for(i=0;i<400;i=i+1) drv($urandom,$urandom,$urandom%2?8'ha8:$urandom,$urandom,$urandom);
 repeat(3) @(posedge mclk); wrap_up; end
endmodule // tb_top
